// File: hw/bcis_regs.svh
// Purpose: constants for the instruction subset core
// Assumes: 12-bit instruction words, 8-bit data path
// Notes: encodings are given as value and care mask
`ifndef BCIS_REGS_SVH
`define BCIS_REGS_SVH
`define BCIS_OPC_RR_VAL 12'h0_300
`define BCIS_OPC_RL_VAL 12'h0_340
`define BCIS_OPC_SWAP_VAL 12'h0_380
`define BCIS_OPC_SUB_VAL 12'h0_080
`define BCIS_OPC_BYTE_MASK 12'h0_FC0
`define BCIS_OPC_SLEEP_VAL 12'h0_003
`define BCIS_OPC_SLEEP_MASK 12'h0_FFF
`define BCIS_OPC_DIR_VAL 12'h0_000
`define BCIS_OPC_DIR_MASK 12'h0_FF8
`define BCIS_DIR_MIN 3'h5
`define BCIS_DIR_MAX 4'h9
`define BCIS_DEST_BIT 5
`define BCIS_FSEL_HI 4
`define BCIS_ST_CARRY 0
`define BCIS_ST_HALF 1
`define BCIS_ST_ZERO 2
`define BCIS_ST_PWRDN 3
`define BCIS_ST_TMOUT 4
`define BCIS_STATUS_RST 8'h0_018
`define BCIS_PHASES 2'h3
`define BCIS_WDOG_RST 8'h0_000
`endif

// File: hw/bcis_pkg.sv
// Purpose: shared types for the instruction subset core
// Assumes: nothing
// Notes: operation kinds after decode
package bcis_pkg;
    typedef enum logic [2:0] {
        BCIS_OP_NONE,
        BCIS_OP_RL,
        BCIS_OP_RR,
        BCIS_OP_SUB,
        BCIS_OP_SWAP,
        BCIS_OP_DIR,
        BCIS_OP_SLEEP
    } bcis_op_t;
    typedef enum logic [1:0] {
        BCIS_FETCH,
        BCIS_FLUSH,
        BCIS_ASLEEP
    } bcis_state_t;
endpackage : bcis_pkg

// File: hw/bcis_core.sv
// Purpose: decode and execute part of a baseline 8-bit instruction set
// Assumes: clk_i is the oscillator; one instruction cycle is four periods
// Notes: other opcodes execute as no-ops in one cycle, two when branch_taken_i is set; sleep ends on reset
`timescale 1ns/100ps
`default_nettype none
`include "bcis_regs.svh"

// Notes on behaviour
// - a byte operation writes the accumulator when d is 0 and the file register when d is 1.
// - bits marked don't-care are ignored by the decoder.
// - an instruction takes one cycle, or two when a test is true or the program counter changes.
// - each instruction cycle is four consecutive oscillator periods.
// - rotate left moves the file register left through carry, touching only carry.
// - rotate right, 0011 00df ffff, moves the file register right through carry only.
// - standby entry, 0000 0000 0011, clears watchdog and prescaler, sets timeout, clears powerdown.
// - after standby entry the core sleeps with its oscillator stopped.
// - subtract, 0000 10df ffff, computes file minus accumulator and sets carry, half carry, zero.
// - after subtract carry is 1 for a result of zero or more and 0 on borrow.
// - nibble exchange, 0011 10df ffff, swaps the nibbles and leaves flags alone.
// - every instruction is one 12-bit word.
// - the file field selects one of 32 registers, 0x00 to 0x1F.
// - timeout sits at status bit 4 and powerdown at status bit 3.
module bcis_core #(
    parameter int DATA_W = 8,
    parameter int INSTR_W = 12,
    parameter int FILE_N = 32,
    parameter int DIR_N = 5
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic branch_taken_i,
    output logic instr_req_o,
    output logic [DATA_W-1:0] acc_o,
    output logic [DATA_W-1:0] status_o,
    output logic [DATA_W-1:0] wdog_o,
    output logic [DATA_W-1:0] prescale_o,
    output logic [DATA_W*DIR_N-1:0] dir_o,
    output logic osc_run_o,
    output logic cycle_o
);
    import bcis_pkg::*;

    localparam int FSEL_W = $clog2(FILE_N);

    function automatic bcis_op_t decode_op(input logic [INSTR_W-1:0] w);
        bcis_op_t op;
        op = BCIS_OP_NONE;
        // masks drop the d and f fields; no other free bits
        if ((w & `BCIS_OPC_BYTE_MASK) == `BCIS_OPC_RL_VAL) op = BCIS_OP_RL;
        else if ((w & `BCIS_OPC_BYTE_MASK) == `BCIS_OPC_RR_VAL) op = BCIS_OP_RR;
        else if ((w & `BCIS_OPC_BYTE_MASK) == `BCIS_OPC_SWAP_VAL) op = BCIS_OP_SWAP;
        else if ((w & `BCIS_OPC_BYTE_MASK) == `BCIS_OPC_SUB_VAL) op = BCIS_OP_SUB;
        else if ((w & `BCIS_OPC_SLEEP_MASK) == `BCIS_OPC_SLEEP_VAL) op = BCIS_OP_SLEEP;
        else if ((w & `BCIS_OPC_DIR_MASK) == `BCIS_OPC_DIR_VAL
            && w[2:0] >= `BCIS_DIR_MIN) op = BCIS_OP_DIR;
        return op;
    endfunction : decode_op

    logic [DATA_W-1:0] file_reg [FILE_N];
    logic [DATA_W-1:0] file_next [FILE_N];
    logic [DATA_W-1:0] dir_reg [DIR_N];
    logic [DATA_W-1:0] dir_next [DIR_N];
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic [DATA_W-1:0] status_reg, status_next;
    logic [DATA_W-1:0] wdog_reg, wdog_next;
    logic [DATA_W-1:0] pre_reg, pre_next;
    logic [1:0] phase_reg, phase_next;
    logic req_reg, req_next;
    logic cyc_reg, cyc_next;
    bcis_state_t state_reg, state_next;

    bcis_op_t op;
    logic [FSEL_W-1:0] fsel;
    logic [DATA_W-1:0] fval, result;
    logic [DATA_W:0] diff;
    logic [DATA_W/2:0] hdiff;
    logic to_file, cycle_end;

    assign op = decode_op(instr_i);
    assign fsel = instr_i[`BCIS_FSEL_HI:0];
    assign fval = file_reg[fsel];
    assign to_file = instr_i[`BCIS_DEST_BIT];
    // 9-bit difference: top bit set means borrow
    assign diff = {1'b0, fval} - {1'b0, acc_reg};
    assign hdiff = {1'b0, fval[DATA_W/2-1:0]} - {1'b0, acc_reg[DATA_W/2-1:0]};
    assign cycle_end = (phase_reg == `BCIS_PHASES);

    // phase counter: four oscillator periods per instruction cycle
    always_comb
    begin
        phase_next = phase_reg;
        cyc_next = 1'b0;
        req_next = 1'b0;
        if (state_reg != BCIS_ASLEEP)
        begin
            phase_next = phase_reg + 2'h1;
            cyc_next = (phase_next == `BCIS_PHASES);
            req_next = (phase_next == `BCIS_PHASES) && (state_next == BCIS_FETCH);
        end
    end

    // sequencing: a taken test or program counter change adds a flush cycle
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            BCIS_FETCH:
            begin
                if (cycle_end && instr_valid_i)
                begin
                    if (op == BCIS_OP_SLEEP)
                        state_next = BCIS_ASLEEP;
                    else if (branch_taken_i)
                        state_next = BCIS_FLUSH;
                end
            end
            BCIS_FLUSH:
            begin
                if (cycle_end)
                    state_next = BCIS_FETCH;
            end
            BCIS_ASLEEP:
            begin
                state_next = BCIS_ASLEEP;
            end
        endcase
    end

    // execute on the last phase of a fetch cycle
    always_comb
    begin
        acc_next = acc_reg;
        status_next = status_reg;
        wdog_next = wdog_reg;
        pre_next = pre_reg;
        result = fval;
        for (int i = 0; i < FILE_N; i++)
            file_next[i] = file_reg[i];
        for (int i = 0; i < DIR_N; i++)
            dir_next[i] = dir_reg[i];
        // prescaler ticks every oscillator period while awake; standby below wins
        if (state_reg != BCIS_ASLEEP)
            pre_next = pre_reg + 8'h01;
        if (state_reg == BCIS_FETCH && cycle_end && instr_valid_i)
        begin
            unique case (op)
                BCIS_OP_RL:
                begin
                    result = {fval[DATA_W-2:0], status_reg[`BCIS_ST_CARRY]};
                    status_next[`BCIS_ST_CARRY] = fval[DATA_W-1];
                end
                BCIS_OP_RR:
                begin
                    result = {status_reg[`BCIS_ST_CARRY], fval[DATA_W-1:1]};
                    status_next[`BCIS_ST_CARRY] = fval[0];
                end
                BCIS_OP_SUB:
                begin
                    result = diff[DATA_W-1:0];
                    status_next[`BCIS_ST_CARRY] = ~diff[DATA_W];
                    status_next[`BCIS_ST_HALF] = ~hdiff[DATA_W/2];
                    status_next[`BCIS_ST_ZERO] = (diff[DATA_W-1:0] == '0);
                end
                BCIS_OP_SWAP:
                begin
                    result = {fval[DATA_W/2-1:0], fval[DATA_W-1:DATA_W/2]};
                end
                BCIS_OP_DIR:
                begin
                    dir_next[instr_i[2:0] - `BCIS_DIR_MIN] = acc_reg;
                end
                BCIS_OP_SLEEP:
                begin
                    wdog_next = `BCIS_WDOG_RST;
                    pre_next = `BCIS_WDOG_RST;
                    status_next[`BCIS_ST_TMOUT] = 1'b1;
                    status_next[`BCIS_ST_PWRDN] = 1'b0;
                end
                BCIS_OP_NONE:
                begin
                end
            endcase
            if (op == BCIS_OP_RL || op == BCIS_OP_RR || op == BCIS_OP_SUB
                || op == BCIS_OP_SWAP)
            begin
                if (to_file)
                    file_next[fsel] = result;
                else
                    acc_next = result;
            end
        end
        else if (state_reg != BCIS_ASLEEP && cycle_end)
        begin
            // watchdog counts only awake instruction cycles that execute no instruction, such as flush cycles
            wdog_next = wdog_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            phase_reg <= 2'h0;
            cyc_reg <= 1'b0;
            req_reg <= 1'b0;
            state_reg <= BCIS_FETCH;
            acc_reg <= '0;
            status_reg <= `BCIS_STATUS_RST;
            wdog_reg <= `BCIS_WDOG_RST;
            pre_reg <= `BCIS_WDOG_RST;
            for (int i = 0; i < FILE_N; i++)
                file_reg[i] <= '0;
            for (int i = 0; i < DIR_N; i++)
                dir_reg[i] <= '1;
        end
        else
        begin
            phase_reg <= phase_next;
            cyc_reg <= cyc_next;
            req_reg <= req_next;
            state_reg <= state_next;
            acc_reg <= acc_next;
            status_reg <= status_next;
            wdog_reg <= wdog_next;
            pre_reg <= pre_next;
            for (int i = 0; i < FILE_N; i++)
                file_reg[i] <= file_next[i];
            for (int i = 0; i < DIR_N; i++)
                dir_reg[i] <= dir_next[i];
        end
    end

    logic osc_reg;
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            osc_reg <= 1'b1;
        else
            osc_reg <= (state_next != BCIS_ASLEEP);
    end

    genvar g;
    generate
        for (g = 0; g < DIR_N; g++)
        begin : g_dir
            assign dir_o[g*DATA_W +: DATA_W] = dir_reg[g];
        end
    endgenerate

    assign instr_req_o = req_reg;
    assign acc_o = acc_reg;
    assign status_o = status_reg;
    assign wdog_o = wdog_reg;
    assign prescale_o = pre_reg;
    assign osc_run_o = osc_reg;
    assign cycle_o = cyc_reg;

    logic exec_now;
    assign exec_now = state_reg == BCIS_FETCH && cycle_end && instr_valid_i;

    sequence s_sleep_exec;
        exec_now && op == BCIS_OP_SLEEP;
    endsequence

    chk_sleep_flags: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_sleep_exec |=> status_o[`BCIS_ST_TMOUT] && !status_o[`BCIS_ST_PWRDN]
        && wdog_o == '0 && prescale_o == '0)
        else $error("standby entry did not set flags");
    chk_sleep_stop: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_sleep_exec |=> ##1 !osc_run_o [*4])
        else $error("oscillator still running in sleep");
    // the standby cycle itself is the last boundary, so it has no successor
    chk_cycle_four: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(cycle_o) && osc_run_o && !(exec_now && op == BCIS_OP_SLEEP)
        |=> !cycle_o [*3] ##1 cycle_o)
        else $error("instruction cycle not four periods");
    chk_sub_carry: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && op == BCIS_OP_SUB |=>
        status_o[`BCIS_ST_CARRY] == ($past(fval) >= $past(acc_reg)))
        else $error("subtract carry wrong");
    chk_sub_zero: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && op == BCIS_OP_SUB |=>
        status_o[`BCIS_ST_ZERO] == ($past(fval) == $past(acc_reg)))
        else $error("subtract zero flag wrong");
    chk_swap_dest: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && op == BCIS_OP_SWAP && !to_file |=>
        acc_o == {$past(fval[3:0]), $past(fval[7:4])} && $stable(status_o))
        else $error("nibble exchange wrong");
    chk_rr_carry: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && op == BCIS_OP_RR |=> status_o[`BCIS_ST_CARRY] == $past(fval[0]))
        else $error("rotate right carry wrong");
    chk_rl_carry: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && op == BCIS_OP_RL |=> status_o[`BCIS_ST_CARRY] == $past(fval[7]))
        else $error("rotate left carry wrong");
    // flush cycle plus three fetch phases quiet, then the next request
    chk_branch_flush: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && branch_taken_i && op != BCIS_OP_SLEEP |=>
        !instr_req_o [*7] ##1 instr_req_o)
        else $error("no extra cycle after branch");
    chk_dir_load: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exec_now && op == BCIS_OP_DIR && instr_i[2:0] == 3'h5 |=>
        dir_o[7:0] == $past(acc_reg))
        else $error("direction load wrong");
endmodule : bcis_core

`default_nettype wire

// File: verification/bcis_prog_mem.sv
// Purpose: program memory model feeding the instruction subset core
// Assumes: one word handed over per fetch request, pc restarts on reset
// Notes: past the loaded program the word bus toggles so stale data never passes
`timescale 1ns/100ps
`default_nettype none
module bcis_prog_mem #(
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic fetch_i,
    output logic [11:0] word_o,
    output logic word_valid_o,
    output logic branch_o
);
    // each entry is the branch flag above a 12-bit word
    logic [12:0] rom [DEPTH];
    int used = 0;
    int pc_reg = 0;
    logic idle_reg = 1'b0;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            pc_reg <= 0;
        end
        else if (fetch_i && pc_reg < used)
        begin
            pc_reg <= pc_reg + 1;
        end
        idle_reg <= ~idle_reg;
    end

    assign word_valid_o = (pc_reg < used);
    assign word_o = word_valid_o ? rom[pc_reg][11:0] : ({12{idle_reg}} ^ 12'ha5a);
    assign branch_o = word_valid_o & rom[pc_reg][12];
endmodule : bcis_prog_mem
`default_nettype wire

// File: verification/test_bcis_core.sv
// Purpose: self-checking bench for the instruction subset core
// Assumes: results are visible one delay step after the execute edge
// Notes: rows run one fixed program; sleep and reset are checked by hand
`timescale 1ns/100ps
`default_nettype none
module test_bcis_core;
    typedef struct packed {
        logic br;
        logic [11:0] ins;
        logic [7:0] acc;
        logic [7:0] st;
    } bcis_row_t;
    localparam int NROW = 17;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] instr;
    logic instr_valid, branch_taken, instr_req, osc_run, cycle;
    logic [7:0] acc, status, wdog, prescale;
    logic [39:0] dir;
    bcis_row_t rows [NROW];
    int miscompares = 0;
    int num_checks = 0;
    int n;

    bcis_core DUT (.clk_i(clk), .reset_i(reset), .instr_i(instr), .instr_valid_i(instr_valid),
        .branch_taken_i(branch_taken), .instr_req_o(instr_req), .acc_o(acc),
        .status_o(status), .wdog_o(wdog), .prescale_o(prescale), .dir_o(dir),
        .osc_run_o(osc_run), .cycle_o(cycle));
    bcis_prog_mem u_mem (.clk_i(clk), .reset_i(reset), .fetch_i(instr_req),
        .word_o(instr), .word_valid_o(instr_valid), .branch_o(branch_taken));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_gap(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_gap

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic chk_reset();
        chk_val(acc, 8'h00);
        chk_val(status, 8'h18);
        chk_val(wdog, 8'h00);
        chk_val(prescale, 8'h00);
        chk_val(dir, 40'hff_ffff_ffff);
        chk_val(osc_run, 1'b1);
        chk_val(cycle, 1'b0);
        chk_val(instr_req, 1'b0);
    endtask : chk_reset

    initial
    begin
        // branch, word, acc after, status after; file regs start at zero
        rows = '{{1'b0, 12'h080, 8'h00, 8'h1f}, {1'b0, 12'h360, 8'h00, 8'h1e},
            {1'b0, 12'h3a0, 8'h00, 8'h1e}, {1'b0, 12'h300, 8'h08, 8'h1e},
            {1'b1, 12'h0a0, 8'h08, 8'h19}, {1'b0, 12'h321, 8'h08, 8'h18},
            {1'b0, 12'h341, 8'h00, 8'h19}, {1'b0, 12'h081, 8'h80, 8'h1b},
            {1'b0, 12'h005, 8'h80, 8'h1b}, {1'b0, 12'h007, 8'h80, 8'h1b},
            {1'b0, 12'h004, 8'h80, 8'h1b}, {1'b0, 12'h081, 8'h00, 8'h1f},
            {1'b0, 12'h33f, 8'h00, 8'h1e}, {1'b0, 12'h39f, 8'h08, 8'h1e},
            {1'b0, 12'h006, 8'h08, 8'h1e}, {1'b1, 12'h0c0, 8'h08, 8'h1e},
            {1'b0, 12'h003, 8'h08, 8'h16}};
        for (int i = 0; i < NROW; i++)
        begin
            u_mem.rom[i] = {rows[i].br, rows[i].ins};
        end
        u_mem.used = NROW;
        repeat (12) @(posedge clk);
        #1;
        chk_reset();
        reset = 1'b0;
        for (int i = 0; i < NROW; i++)
        begin
            n = 0;
            while (instr_req !== 1'b1 && n < 12)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            if (n >= 12)
            begin
                miscompares++;
                final_report();
            end
            chk_val(cycle, 1'b1);
            @(posedge clk);
            #1;
            n++;
            // a branch row adds a flush cycle before the next word
            chk_gap(n, (i > 0 && rows[i - 1].br) ? 8 : 4);
            chk_val(acc, rows[i].acc);
            chk_val(status, rows[i].st);
            // prescaler has seen four oscillator periods at the first execute
            if (i == 0)
                chk_val(prescale, 8'h04);
        end
        chk_val(wdog, 8'h00);
        chk_val(prescale, 8'h00);
        chk_val(dir, 40'hff_ff80_0880);
        n = 0;
        repeat (12)
        begin
            @(posedge clk);
            #1;
            if (cycle !== 1'b0 || instr_req !== 1'b0)
                n++;
        end
        chk_gap(n, 0);
        chk_val(osc_run, 1'b0);
        chk_val(acc, 8'h08);
        // only reset wakes the core
        reset = 1'b1;
        @(posedge clk);
        #1;
        chk_reset();
        final_report();
    end
endmodule : test_bcis_core
`default_nettype wire
